// >>> hw/accumulator_shift_store_unit.sv
/*
 * Accumulator shift-and-store unit: shifts a 40-bit accumulator, rounds,
 * checks overflow, saturates and writes one 16-bit part to data memory,
 * once per iteration of a single-instruction repeat.
 * Assumes a decoder that presents one store at a time with valid/ready
 * and a memory write port that always accepts; addresses come from the
 * address generator, sampled in each iteration.
 */
`timescale 1ns/1ps
`include "accshift_defs.svh"

module accumulator_shift_store_unit (
    // Clock and reset
    input  wire logic                     CLK_I,
    input  wire logic                     RST_N_I,
    // Store request from the decoder
    input  wire logic                     REQ_VALID_I,
    output logic                          REQ_READY_O,
    input  wire accshift_pkg::store_req_t REQ_I,
    // Status-register mode bits
    input  wire accshift_pkg::mode_bits_t MODE_I,
    // Address of the current iteration
    input  wire logic [`ADDR_W-1:0]       MEM_ADDR_I,
    // Data-memory write port
    output accshift_pkg::mem_write_t      MEM_WR_O,
    output logic                          BUSY_O
);
    accshift_pkg::seq_state_t state_r, state_nxt;
    accshift_pkg::store_req_t req_r;
    accshift_pkg::mode_bits_t mode_r;
    accshift_pkg::mem_write_t wr_r, wr_nxt;
    logic [`REP_W-1:0]        cnt_r, cnt_nxt;

    logic                     accept;
    logic                     run;
    logic                     is_reg;
    logic                     legacy_force;
    logic                     uns_eff;
    logic                     sat_eff;
    logic                     rnd_eff;
    logic                     rnd_req;
    logic                     sign_fill;
    logic [`SHIFT_W-1:0]      amt;
    logic [`ACC_W-1:0]        shifted;
    logic [`ACC_W-1:0]        res;
    logic                     op_sign;
    logic                     ovf_uns;
    logic                     ovf_sgn;
    logic                     ovf;
    logic [`ACC_W-1:0]        sat_val;
    logic [`ACC_W-1:0]        final_val;
    logic [`WORD_W-1:0]       store_word;

    // Handshake: one store instruction at a time
    assign accept      = REQ_VALID_I && (state_r == accshift_pkg::ST_IDLE);
    assign run         = (state_r == accshift_pkg::ST_RUN);
    assign REQ_READY_O = (state_r == accshift_pkg::ST_IDLE);
    assign BUSY_O      = run;
    assign MEM_WR_O    = wr_r;

    // Qualifier policy; legacy saturate mode overrides the instruction
    assign is_reg       = (req_r.form == accshift_pkg::FORM_REG_HI);
    assign legacy_force = mode_r.legacy_compat_mode_bit && mode_r.store_saturate_bit;
    assign uns_eff      = legacy_force ? !mode_r.sign_extension_mode_bit : req_r.uns_q;
    assign sat_eff      = legacy_force || req_r.sat_q;
    assign rnd_req      = legacy_force || req_r.rnd_q;
    assign rnd_eff      = is_reg && rnd_req;
    // Unsigned treatment forces zero fill regardless of the sign mode
    assign sign_fill    = mode_r.sign_extension_mode_bit && !uns_eff;

    shift_amount_sel u_amt (
        .temp_i     (req_r.temp_shift),
        .imm_i      (req_r.immediate_shift_field),
        .from_reg_i (is_reg),
        .compat_i   (mode_r.legacy_compat_mode_bit),
        .amt_o      (amt)
    );

    acc_shift_round u_shift (
        .acc_i       (req_r.source_accumulator),
        .amt_i       (amt),
        .sign_fill_i (sign_fill),
        .rnd_en_i    (rnd_eff),
        .rdm_i       (mode_r.rounding_method_bit),
        .shifted_o   (shifted),
        .res_o       (res)
    );

    // Overflow on the 40-bit shift-and-round result
    assign op_sign  = req_r.source_accumulator[`ACC_W-1] && mode_r.sign_extension_mode_bit;
    assign ovf_uns  = |res[`ACC_W-1:`UNS_CHK_LSB];
    assign ovf_sgn  = res[`ACC_W-1:`SGN_CHK_LSB] != {`SGN_CHK_W{op_sign}};
    assign ovf      = uns_eff ? ovf_uns : ovf_sgn;

    // Saturation touches only the stored word; no flag leaves the unit
    assign sat_val    = uns_eff ? `SAT_UNS : (op_sign ? `SAT_NEG : `SAT_POS);
    assign final_val  = (sat_eff && ovf) ? sat_val : res;
    assign store_word = (req_r.form == accshift_pkg::FORM_IMM_LO)
                        ? final_val[`LO_MSB:`LO_LSB]
                        : final_val[`HI_MSB:`HI_LSB];

    // Sequencer: rep_cnt extra iterations after the first
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            accshift_pkg::ST_IDLE: begin
                if (accept) begin
                    state_nxt = accshift_pkg::ST_RUN;
                    cnt_nxt   = REQ_I.rep_cnt;
                end
            end
            accshift_pkg::ST_RUN: begin
                if (cnt_r == `REP_RST) begin
                    state_nxt = accshift_pkg::ST_IDLE;
                end else begin
                    cnt_nxt = cnt_r - `REP_W'(1);
                end
            end
            default: begin
                state_nxt = accshift_pkg::ST_IDLE;
            end
        endcase
    end

    // One write per iteration, registered toward memory
    always_comb begin
        wr_nxt      = '0;
        wr_nxt.we   = run;
        wr_nxt.addr = run ? MEM_ADDR_I : '0;
        wr_nxt.data = run ? store_word : '0;
    end

    // Sequencer and output registers
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            state_r <= accshift_pkg::ST_IDLE;
            cnt_r   <= `REP_RST;
            wr_r    <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            wr_r    <= wr_nxt;
        end
    end

    // Instruction and modes held steady over the repeat
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            req_r  <= '0;
            mode_r <= '0;
        end else if (accept) begin
            req_r  <= REQ_I;
            mode_r <= MODE_I;
        end
    end

    // Checks on the datapath and sequencer
    property p_hi_store;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && is_reg && !(sat_eff && ovf) |=> MEM_WR_O.we && MEM_WR_O.data == $past(res[31:16]);
    endproperty
    a_hi_store: assert property (p_hi_store) else $error("high store data wrong");

    property p_clamp;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && is_reg && !mode_r.legacy_compat_mode_bit |->
            ($signed(req_r.temp_shift) > 16'sd31 ? amt == 6'h1F :
             $signed(req_r.temp_shift) < -16'sd32 ? amt == 6'h20 :
             amt == req_r.temp_shift[5:0]);
    endproperty
    a_clamp: assert property (p_clamp) else $error("shift clamp wrong");

    property p_fill;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && amt[5] |-> shifted[39] == (req_r.source_accumulator[39] && sign_fill);
    endproperty
    a_fill: assert property (p_fill) else $error("extension wrong");

    property p_no_rnd_imm;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && !is_reg |-> res == shifted;
    endproperty
    a_no_rnd_imm: assert property (p_no_rnd_imm) else $error("immediate store rounded");

    property p_legacy_amt;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && is_reg && mode_r.legacy_compat_mode_bit && req_r.temp_shift[5:4] == 2'h2 |->
            amt == req_r.temp_shift[5:0] + 6'h10;
    endproperty
    a_legacy_amt: assert property (p_legacy_amt) else $error("legacy wrap wrong");

    property p_force_uns;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && legacy_force && !mode_r.sign_extension_mode_bit |->
            uns_eff && sat_eff && (rnd_eff == is_reg);
    endproperty
    a_force_uns: assert property (p_force_uns) else $error("legacy unsigned force wrong");

    property p_force_sgn;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && legacy_force && mode_r.sign_extension_mode_bit |-> !uns_eff && sat_eff;
    endproperty
    a_force_sgn: assert property (p_force_sgn) else $error("legacy signed force wrong");

    property p_uns_sat;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && uns_eff && sat_eff && res[39:32] != 8'h00 |-> final_val == `SAT_UNS;
    endproperty
    a_uns_sat: assert property (p_uns_sat) else $error("unsigned saturation wrong");

    property p_lo_store;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && req_r.form == accshift_pkg::FORM_IMM_LO |=> MEM_WR_O.data == $past(final_val[15:0]);
    endproperty
    a_lo_store: assert property (p_lo_store) else $error("low store data wrong");

    property p_repeat;
        @(posedge CLK_I) disable iff (!RST_N_I)
        accept && REQ_I.rep_cnt == 16'h0003 |=> run[*4] ##1 !run;
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeat count wrong");

    // Port must read all zero between repeats, so a stale word cannot land
    property p_wr_idle;
        @(posedge CLK_I) disable iff (!RST_N_I)
        !run |=> MEM_WR_O == '0;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write outside repeat");

    property p_round;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && rnd_eff && !mode_r.rounding_method_bit |->
            res[39:16] == shifted[39:16] + 24'(shifted[15]) && res[15:0] == 16'h0000;
    endproperty
    a_round: assert property (p_round) else $error("rounding wrong");

    property p_conv;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && rnd_eff && mode_r.rounding_method_bit && shifted[15:0] == 16'h8000 |->
            res[39:16] == shifted[39:16] + 24'(shifted[16]);
    endproperty
    a_conv: assert property (p_conv) else $error("convergent tie wrong");

    property p_no_rnd;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && !legacy_force && !req_r.rnd_q |-> res == shifted;
    endproperty
    a_no_rnd: assert property (p_no_rnd) else $error("unrequested rounding");

    property p_six_lsb;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && is_reg && mode_r.legacy_compat_mode_bit && req_r.temp_shift[5:4] != 2'h2 |->
            amt == req_r.temp_shift[5:0];
    endproperty
    a_six_lsb: assert property (p_six_lsb) else $error("legacy shift bits wrong");

    property p_sgn_pos;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && sat_eff && !uns_eff && !req_r.source_accumulator[39] && res[39:31] != 9'h000
            |-> final_val == `SAT_POS;
    endproperty
    a_sgn_pos: assert property (p_sgn_pos) else $error("positive saturation wrong");

    property p_sgn_neg;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && sat_eff && !uns_eff && mode_r.sign_extension_mode_bit &&
            req_r.source_accumulator[39] && res[39:31] != 9'h1FF |-> final_val == `SAT_NEG;
    endproperty
    a_sgn_neg: assert property (p_sgn_neg) else $error("negative saturation wrong");

    property p_imm_hi;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && req_r.form == accshift_pkg::FORM_IMM_HI && !(sat_eff && ovf) |=>
            MEM_WR_O.data == $past(shifted[31:16]);
    endproperty
    a_imm_hi: assert property (p_imm_hi) else $error("immediate high store wrong");

    property p_no_sat;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && !sat_eff |-> final_val == res;
    endproperty
    a_no_sat: assert property (p_no_sat) else $error("unrequested saturation");

    property p_imm_uns;
        @(posedge CLK_I) disable iff (!RST_N_I)
        run && !is_reg && legacy_force && !mode_r.sign_extension_mode_bit |->
            uns_eff && sat_eff && !rnd_eff && !sign_fill;
    endproperty
    a_imm_uns: assert property (p_imm_uns) else $error("immediate unsigned force wrong");

endmodule : accumulator_shift_store_unit

// >>> hw/accshift_defs.svh
/*
 * Constants of the accumulator shift-and-store unit: widths, field
 * positions, shift limits, rounding and saturation values.
 * Assumes it is included once per compilation unit through its guard.
 */
`ifndef ACCSHIFT_DEFS_SVH
`define ACCSHIFT_DEFS_SVH

// Widths
`define ACC_W          40
`define WORD_W         16
`define ADDR_W         24
`define TEMP_W         16
`define SHIFT_W        6
`define REP_W          16
`define EXT_W          32

// Stored field positions inside the shifted accumulator
`define HI_LSB         16
`define HI_MSB         31
`define LO_LSB         0
`define LO_MSB         15

// Overflow check windows
`define UNS_CHK_LSB    32
`define SGN_CHK_LSB    31
`define SGN_CHK_W      9

// Register shift limits, at the temporary-register width and at the six-bit shift width
`define SHIFT_MAX      16'h001F
`define SHIFT_MIN      16'hFFE0
`define SHIFT_MAX6     6'h1F
`define SHIFT_MIN6     6'h20

// Rounding constants
`define RND_HALF       40'h0000008000
`define RND_TIE        16'h8000

// Saturation values
`define SAT_UNS        40'h00FFFFFFFF
`define SAT_POS        40'h007FFFFFFF
`define SAT_NEG        40'hFF80000000

// Reset values
`define REP_RST        16'h0000

`endif

// >>> hw/accshift_pkg.sv
/*
 * Types of the accumulator shift-and-store unit: store forms, mode bits,
 * request bundle and memory write bundle.
 * Assumes accshift_defs.svh is on the include path.
 */
`include "accshift_defs.svh"

package accshift_pkg;

    // Store forms handled by the unit
    typedef enum logic [1:0] {
        FORM_REG_HI,
        FORM_IMM_LO,
        FORM_IMM_HI
    } store_form_t;

    // Control state of the repeat sequencer
    typedef enum logic {
        ST_IDLE,
        ST_RUN
    } seq_state_t;

    // Status-register mode bits that steer the store
    typedef struct packed {
        logic legacy_compat_mode_bit;
        logic store_saturate_bit;
        logic sign_extension_mode_bit;
        logic rounding_method_bit;
    } mode_bits_t;

    // One decoded store instruction
    typedef struct packed {
        store_form_t                form;
        logic                       rnd_q;
        logic                       uns_q;
        logic                       sat_q;
        logic [`REP_W-1:0]          rep_cnt;
        logic [`ACC_W-1:0]          source_accumulator;
        logic [`TEMP_W-1:0]         temp_shift;
        logic [`SHIFT_W-1:0]        immediate_shift_field;
    } store_req_t;

    // One data-memory word write
    typedef struct packed {
        logic                       we;
        logic [`ADDR_W-1:0]         addr;
        logic [`WORD_W-1:0]         data;
    } mem_write_t;

endpackage : accshift_pkg

// >>> hw/shift_amount_sel.sv
/*
 * Picks the signed shift quantity: clamped temporary register, legacy
 * six-bit temporary register with modulo-16 wrap, or the immediate field.
 * Purely combinational; the caller holds the operands stable.
 */
`timescale 1ns/1ps
`include "accshift_defs.svh"

module shift_amount_sel (
    // Operands
    input  wire logic [`TEMP_W-1:0]   temp_i,
    input  wire logic [`SHIFT_W-1:0]  imm_i,
    // Selection
    input  wire logic                 from_reg_i,
    input  wire logic                 compat_i,
    // Result, two's complement
    output logic      [`SHIFT_W-1:0]  amt_o
);
    logic signed [`TEMP_W-1:0] temp_s;
    logic        [`SHIFT_W-1:0] clamp_amt;
    logic        [`SHIFT_W-1:0] legacy_amt;
    logic                       low_band;

    // Native form saturates the 16-bit quantity to -32..+31
    assign temp_s     = $signed(temp_i);
    assign clamp_amt  = (temp_s > $signed(`SHIFT_MAX)) ? `SHIFT_MAX6 :
                        (temp_s < $signed(`SHIFT_MIN)) ? `SHIFT_MIN6 :
                        temp_i[`SHIFT_W-1:0];

    // Legacy form: -32..-17 has top bits 10, adding 16 sets bit 4
    assign low_band   = (temp_i[5:4] == 2'h2);
    assign legacy_amt = low_band ? {2'h3, temp_i[3:0]} : temp_i[`SHIFT_W-1:0];

    assign amt_o = !from_reg_i ? imm_i : (compat_i ? legacy_amt : clamp_amt);

endmodule : shift_amount_sel

// >>> hw/acc_shift_round.sv
/*
 * Forty-bit accumulator shifter with optional rounding of the high word.
 * Left shifts up to 31, right shifts up to 32; combinational only.
 */
`timescale 1ns/1ps
`include "accshift_defs.svh"

module acc_shift_round (
    // Operand and amount
    input  wire logic [`ACC_W-1:0]    acc_i,
    input  wire logic [`SHIFT_W-1:0]  amt_i,
    // Controls
    input  wire logic                 sign_fill_i,
    input  wire logic                 rnd_en_i,
    input  wire logic                 rdm_i,
    // Result
    output logic      [`ACC_W-1:0]    shifted_o,
    output logic      [`ACC_W-1:0]    res_o
);
    localparam int WIDE_W = `ACC_W + `EXT_W;

    logic signed [WIDE_W-1:0]  wide;
    logic        [WIDE_W-1:0]  moved;
    logic        [`SHIFT_W-1:0] right_amt;
    logic        [`ACC_W-1:0]  rounded;
    logic                      tie_even;

    // Extension happens before the shift so right shifts pull in the fill
    assign wide      = $signed({{`EXT_W{sign_fill_i & acc_i[`ACC_W-1]}}, acc_i});
    assign right_amt = `SHIFT_W'(~amt_i + `SHIFT_W'(1));
    assign moved     = amt_i[`SHIFT_W-1] ? WIDE_W'(wide >>> right_amt)
                                         : WIDE_W'(wide << amt_i[`SHIFT_W-2:0]);
    assign shifted_o = moved[`ACC_W-1:0];

    // Convergent mode leaves an exact tie on an even high word untouched
    assign tie_even = rdm_i && (shifted_o[`LO_MSB:0] == `RND_TIE) && !shifted_o[`HI_LSB];
    assign rounded  = tie_even ? shifted_o : `ACC_W'(shifted_o + `RND_HALF);
    assign res_o    = rnd_en_i ? {rounded[`ACC_W-1:`HI_LSB], {`HI_LSB{1'b0}}} : shifted_o;

endmodule : acc_shift_round

// >>> tb/mem_port_model.sv
/*
 * Data-memory write port model: logs every word the unit writes and
 * supplies the address generator's per-iteration address.
 * Assumes the unit's registered write bundle and busy flag.
 */
`timescale 1ns/1ps
`include "accshift_defs.svh"

module mem_port_model #(
    parameter logic [`ADDR_W-1:0] BASE = 24'h000100
) (
    // Clock and reset
    input  wire logic                     clk_i,
    input  wire logic                     rst_n_i,
    // Unit side
    input  wire logic                     busy_i,
    input  wire accshift_pkg::mem_write_t wr_i,
    output logic      [`ADDR_W-1:0]       addr_o
);
    logic [`WORD_W-1:0] data_q[$];
    logic [`ADDR_W-1:0] addr_q[$];
    logic [`ADDR_W-1:0] iter_r;

    // One address step per RUN cycle, restart between stores
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            iter_r <= 24'h000000;
        end else if (busy_i) begin
            iter_r <= iter_r + 24'h000001;
        end else begin
            iter_r <= 24'h000000;
        end
    end

    // Outside a repeat the bus carries junk, so a stale value cannot pass
    assign addr_o = busy_i ? BASE + iter_r : ~(BASE + iter_r);

    // Port always accepts; each pulse is one stored word
    always @(posedge clk_i) begin
        if (wr_i.we) begin
            data_q.push_back(wr_i.data);
            addr_q.push_back(wr_i.addr);
        end
    end
endmodule : mem_port_model

// >>> tb/testbench.sv
/*
 * Self-checking bench of the accumulator shift-and-store unit.
 * Assumes the package, the header and the memory port model are compiled.
 */
`timescale 1ns/1ps
`include "accshift_defs.svh"

module testbench;
    localparam logic [23:0] BASE = 24'h000100;
    localparam accshift_pkg::store_form_t RH = accshift_pkg::FORM_REG_HI;
    localparam accshift_pkg::store_form_t IL = accshift_pkg::FORM_IMM_LO;
    localparam accshift_pkg::store_form_t IH = accshift_pkg::FORM_IMM_HI;
    logic                     clk;
    logic                     rst_n;
    logic                     valid;
    logic                     ready;
    logic                     busy;
    logic                     rdy_run;
    logic                     busy_run;
    logic [23:0]              addr;
    accshift_pkg::store_req_t req;
    accshift_pkg::mode_bits_t mode;
    accshift_pkg::mem_write_t wr;
    int                       n_errors = 0;
    int                       num_checks = 0;

    // Free-running 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    accumulator_shift_store_unit DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .REQ_VALID_I(valid), .REQ_READY_O(ready),
        .REQ_I(req), .MODE_I(mode), .MEM_ADDR_I(addr), .MEM_WR_O(wr), .BUSY_O(busy)
    );

    mem_port_model #(.BASE(BASE)) mem_model (
        .clk_i(clk), .rst_n_i(rst_n), .busy_i(busy), .wr_i(wr), .addr_o(addr)
    );

    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish;
        if (n_errors == 0 && num_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish

    // One store; q is {rnd, uns, sat}, md is {compat, saturate, sign, round}
    task automatic store(input accshift_pkg::store_form_t f, input logic [2:0] q,
                         input logic [15:0] rep, input logic [39:0] acc,
                         input logic [15:0] tmp, input logic [5:0] imm,
                         input logic [3:0] md, output logic [15:0] w);
        int k;
        mem_model.data_q.delete();
        mem_model.addr_q.delete();
        @(negedge clk);
        req = accshift_pkg::store_req_t'({f, q, rep, acc, tmp, imm});
        mode = accshift_pkg::mode_bits_t'(md);
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        rdy_run = ready;
        busy_run = busy;
        // Bounded wait for the last write to pass
        for (k = 0; k < 200 && (busy || wr.we); k++) @(negedge clk);
        w = (mem_model.data_q.size() > 0) ? mem_model.data_q[0] : 16'hXXXX;
    endtask : store

    task automatic t_reg_shift;
        logic [15:0] w;
        store(RH, 3'h0, 16'h0000, 40'h0000123456, 16'h0004, 6'h00, 4'h0, w);
        check("reg hi", w, 40'h0123);
        store(RH, 3'h0, 16'h0000, 40'h0000000001, 16'h0040, 6'h00, 4'h0, w);
        check("clamp up", w, 40'h8000);
        store(RH, 3'h0, 16'h0000, 40'h8000000000, 16'hFF00, 6'h00, 4'h2, w);
        check("clamp down", w, 40'hFFFF);
        store(RH, 3'h0, 16'h0000, 40'h8000000000, 16'hFFE0, 6'h00, 4'h0, w);
        check("zero fill", w, 40'h0000);
    endtask : t_reg_shift

    task automatic t_round;
        logic [15:0] w;
        store(RH, 3'h4, 16'h0000, 40'h0012348000, 16'h0000, 6'h00, 4'h0, w);
        check("round add", w, 40'h1235);
        store(RH, 3'h4, 16'h0000, 40'h0012348000, 16'h0000, 6'h00, 4'h1, w);
        check("tie even", w, 40'h1234);
        store(RH, 3'h4, 16'h0000, 40'h0012358000, 16'h0000, 6'h00, 4'h1, w);
        check("tie odd", w, 40'h1236);
        store(RH, 3'h0, 16'h0000, 40'h0012348000, 16'h0000, 6'h00, 4'h0, w);
        check("no round", w, 40'h1234);
        store(RH, 3'h3, 16'h0000, 40'h0080000000, 16'h0000, 6'h00, 4'h2, w);
        check("uns window", w, 40'h8000);
        store(RH, 3'h1, 16'h0000, 40'h0080000000, 16'h0000, 6'h00, 4'h2, w);
        check("sgn window", w, 40'h7FFF);
    endtask : t_round

    task automatic t_legacy;
        logic [15:0] w;
        store(RH, 3'h0, 16'h0000, 40'h0000001234, 16'h0144, 6'h00, 4'h8, w);
        check("six lsbs", w, 40'h0001);
        store(RH, 3'h0, 16'h0000, 40'h0012340000, 16'hFFE4, 6'h00, 4'h8, w);
        check("wrap -28", w, 40'h0001);
        store(RH, 3'h0, 16'h0000, 40'h0012340000, 16'hFFEF, 6'h00, 4'h8, w);
        check("wrap -17", w, 40'h091A);
        store(RH, 3'h0, 16'h0000, 40'h0100000000, 16'h0000, 6'h00, 4'hC, w);
        check("uns sat", w, 40'hFFFF);
        store(RH, 3'h0, 16'h0000, 40'h0080000000, 16'h0000, 6'h00, 4'hC, w);
        check("uns kept", w, 40'h8000);
        store(RH, 3'h0, 16'h0000, 40'h0012348000, 16'h0000, 6'h00, 4'hC, w);
        check("forced rnd", w, 40'h1235);
        store(RH, 3'h0, 16'h0000, 40'h0080000000, 16'h0000, 6'h00, 4'hE, w);
        check("pos sat", w, 40'h7FFF);
        store(RH, 3'h0, 16'h0000, 40'hFF00000000, 16'h0000, 6'h00, 4'hE, w);
        check("neg sat", w, 40'h8000);
        store(RH, 3'h0, 16'h0000, 40'h0012348000, 16'h0000, 6'h00, 4'hE, w);
        check("sgn rnd", w, 40'h1235);
    endtask : t_legacy

    task automatic t_imm;
        logic [15:0] w;
        store(IL, 3'h0, 16'h0000, 40'h0000001234, 16'h0000, 6'h04, 4'h0, w);
        check("imm lo", w, 40'h2340);
        store(IL, 3'h0, 16'h0000, 40'h0000001234, 16'h0000, 6'h3C, 4'h0, w);
        check("imm right", w, 40'h0123);
        store(IH, 3'h4, 16'h0000, 40'h0000123480, 16'h0000, 6'h08, 4'h0, w);
        check("imm hi", w, 40'h1234);
        store(IL, 3'h0, 16'h0000, 40'h0001000000, 16'h0000, 6'h08, 4'h8, w);
        check("no force", w, 40'h0000);
        store(IL, 3'h0, 16'h0000, 40'h0001000000, 16'h0000, 6'h08, 4'hC, w);
        check("imm uns", w, 40'hFFFF);
        store(IH, 3'h0, 16'h0000, 40'h0040000000, 16'h0000, 6'h01, 4'hE, w);
        check("imm sgn", w, 40'h7FFF);
        store(IH, 3'h4, 16'h0000, 40'h0000123480, 16'h0000, 6'h08, 4'hE, w);
        check("imm no rnd", w, 40'h1234);
        store(IL, 3'h3, 16'h0000, 40'h0100000000, 16'h0000, 6'h00, 4'h0, w);
        check("uns qual", w, 40'hFFFF);
    endtask : t_imm

    task automatic t_repeat;
        logic [15:0] w;
        int          k;
        store(IL, 3'h0, 16'h0003, 40'h0000001234, 16'h0000, 6'h00, 4'h0, w);
        check("ready run", 40'(rdy_run), 40'h0);
        check("busy run", 40'(busy_run), 40'h1);
        check("count", 40'(mem_model.data_q.size()), 40'h4);
        for (k = 0; k < 4; k++) begin
            check("rep addr", 40'(mem_model.addr_q[k]), 40'(BASE + 24'(k)));
            check("rep data", 40'(mem_model.data_q[k]), 40'h1234);
        end
    endtask : t_repeat

    // Reset cuts a long repeat; nothing of it may leak into the next store
    task automatic t_reset;
        logic [15:0] w;
        @(negedge clk);
        req = accshift_pkg::store_req_t'({IL, 3'h0, 16'h0010, 40'h0000005678, 16'h0000, 6'h00});
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        check("rst ready", 40'(ready), 40'h1);
        check("rst busy", 40'(busy), 40'h0);
        check("rst we", 40'(wr.we), 40'h0);
        check("rst word", 40'({wr.addr, wr.data}), 40'h0);
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        store(IL, 3'h0, 16'h0000, 40'h0000001234, 16'h0000, 6'h00, 4'h0, w);
        check("post rst", w, 40'h1234);
        check("post count", 40'(mem_model.data_q.size()), 40'h1);
    endtask : t_reset

    // Watchdog well beyond the roughly 150 cycles the run needs
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst_n = 1'b0;
        valid = 1'b0;
        req = '0;
        mode = '0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        t_reg_shift();
        t_round();
        t_legacy();
        t_imm();
        t_repeat();
        t_reset();
        tally_and_finish();
    end
endmodule : testbench
